// ==== port_cfg_pkg.sv ====
// Purpose: shared constants for the port merge and upstream failover block
// Assumes: 125 MHz core clock, AXI4-Lite register access with 32-bit data
// Notes: strap encodings and register offsets are fixed here only
package port_cfg_pkg;
  // clock and timing
  localparam int CLK_NS = 8;
  localparam int US_NS = 1000; // watchdog decrements once per microsecond
  localparam int TICK_CYC = (US_NS + CLK_NS - 1) / CLK_NS;
  localparam int DOWN_NS = 128; // upstream link held in detect after a failover
  localparam int DOWN_CYC = (DOWN_NS + CLK_NS - 1) / CLK_NS;

  // switch mode strap encodings
  localparam logic [3:0] SWM_NORMAL = 4'h0;
  localparam logic [3:0] SWM_EEPROM = 4'h1;
  localparam logic [3:0] SWM_FO_P0 = 4'h8;
  localparam logic [3:0] SWM_FO_P2 = 4'h9;
  localparam logic [3:0] SWM_EE_FO_P0 = 4'hA;
  localparam logic [3:0] SWM_EE_FO_P2 = 4'hB;

  // register byte offsets
  localparam logic [7:0] OFS_FO_STATUS = 8'h00; // failover_status_reg
  localparam logic [7:0] OFS_FO_CTRL = 8'h04;
  localparam logic [7:0] OFS_SW_CTRL = 8'h08; // switch_control_reg
  localparam logic [7:0] OFS_WDOG = 8'h0C;
  localparam logic [7:0] OFS_LINK_CAP = 8'h10; // link_capabilities_reg widths

  // failover_status_reg fields
  localparam int ST_FO_EN = 0; // failover_enabled_bit
  localparam int ST_CUR_UP = 1; // current_upstream_field, 0 = port 0, 1 = port 2
  localparam int ST_CHANGED = 2; // upstream_changed_bit, write one to clear
  localparam int ST_ACTIVE_LSB = 8;
  localparam int ST_X8_LSB = 16;
  // failover control fields
  localparam int CT_SEL = 0;
  localparam int CT_SIG_EN = 1;
  localparam int CT_TIM_EN = 2;
  // switch control fields
  localparam int SC_NO_LD_HRST = 0; // disable_linkdown_hot_reset_bit

  // max_link_width_field values
  localparam logic [5:0] WIDTH_X4 = 6'h04;
  localparam logic [5:0] WIDTH_X8 = 6'h08;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    FO_IDLE = 2'b00,
    FO_DOWN = 2'b01,
    FO_SWAP = 2'b10
  } fo_state_t;
endpackage

// ==== port_cfg_top.sv ====
// Purpose: port merge, disable and upstream failover configuration of the switch
// Assumes: RSTN is the fundamental reset, HOT_RSTN the hot reset, both synchronous
// Notes: straps are caught on every edge while RSTN is low and frozen at release
//
// Overview of operation
// - eight x4 ports, port 0 upstream
// - even/odd pair may merge into x8
// - merge fixed only at fundamental reset
// - merged odd port: outputs negated, inputs ignored
// - config to merged odd port is UR
// - merged odd registers unreachable over SMBus
// - odd lanes join the even port
// - merged port max width reads x8
// - disabled port negated; disabled odd voids merge
// - config to disabled port is UR
// - disabled port registers unreachable over SMBus
// - failover only from four strap modes
// - stack 0 fed by port 0 or 2
// - failover disables port 2; x8 also 1,3
// - x4 failover keeps ports 1 and 3
// - upstream resources stay on port 0
// - failover retrains upstream link from detect
// - hot reset suppressed by switch control bit
// - failover enabled status; controls inert otherwise
// - current upstream port always readable
// - sticky change bit, hot reset immune
// - watchdog picks the non-current port
`timescale 1ns/1ns
`default_nettype none
module port_cfg_top
  import port_cfg_pkg::*;
#(
  parameter int WDOG_W = 32
) (
  input wire logic CORE_CLK, // core clock
  input wire logic RSTN, // fundamental reset, active low
  input wire logic HOT_RSTN, // hot reset, active low
  input wire logic [3:0] MERGE_STRAP, // pair_merge_strap per pair 01,23,45,67
  input wire logic [3:0] SWITCH_MODE_STRAPS, // switch_mode_straps
  input wire logic [7:0] PORT_DIS_STRAP, // per-port disable, bit 0 ignored (port 0 always active)
  input wire logic [7:0] PORT_OUT_REQ, // per-port output from port logic
  output logic [7:0] PORT_OUT, // gated per-port output
  input wire logic [7:0] PORT_IN, // per-port input from pins
  output logic [7:0] PORT_IN_OK, // gated per-port input
  output logic [7:0] PORT_ACTIVE, // port enabled
  output logic [3:0] PORT_X8, // even port runs x8
  output logic LANE_SEL, // stack 0 lanes: 0 port 0, 1 port 2
  output logic LINK_DOWN, // upstream held in detect
  output logic HOT_RST_REQ, // hot reset request pulse
  input wire logic UPSTREAM_SEL, // upstream select signal, high selects port 2
  input wire logic CFG_VALID, // config request on virtual bus
  input wire logic [2:0] CFG_DEV, // device number
  output logic CFG_DONE, // config answer pulse
  output logic CFG_UR, // unsupported request
  input wire logic SMB_VALID, // SMBus register access
  input wire logic [2:0] SMB_PORT, // target port
  output logic SMB_DONE, // SMBus answer pulse
  output logic SMB_OK, // target reachable
  input wire logic [7:0] AWADDR, // write address
  input wire logic AWVALID, // write address valid
  output logic AWREADY, // write address ready
  input wire logic [31:0] WDATA, // write data
  input wire logic [3:0] WSTRB, // byte enables
  input wire logic WVALID, // write data valid
  output logic WREADY, // write data ready
  output logic [1:0] BRESP, // write response
  output logic BVALID, // write response valid
  input wire logic BREADY, // write response ready
  input wire logic [7:0] ARADDR, // read address
  input wire logic ARVALID, // read address valid
  output logic ARREADY, // read address ready
  output logic [31:0] RDATA, // read data
  output logic [1:0] RRESP, // read response
  output logic RVALID, // read data valid
  input wire logic RREADY // read data ready
);

  // byte-lane merge used by the failover control and watchdog registers
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] dat,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == OFS_FO_STATUS || a == OFS_FO_CTRL || a == OFS_SW_CTRL ||
           a == OFS_WDOG || a == OFS_LINK_CAP;
  endfunction

  // strap capture, fundamental reset only
  logic [3:0] merge_r;
  logic [3:0] switch_mode_straps_r;
  logic [7:0] dis_r;
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      merge_r <= MERGE_STRAP;
      switch_mode_straps_r <= SWITCH_MODE_STRAPS;
      dis_r <= PORT_DIS_STRAP;
    end
  end

  // derived configuration
  logic fo_mode;
  logic fo_init_p2;
  logic [3:0] merge_eff;
  logic [7:0] active;
  assign fo_mode = switch_mode_straps_r == SWM_FO_P0 || switch_mode_straps_r == SWM_FO_P2 ||
                   switch_mode_straps_r == SWM_EE_FO_P0 || switch_mode_straps_r == SWM_EE_FO_P2;
  assign fo_init_p2 = switch_mode_straps_r == SWM_FO_P2 || switch_mode_straps_r == SWM_EE_FO_P2;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      merge_eff[k] = merge_r[k] & ~dis_r[2*k+1];
    end
    active = ~dis_r;
    active[0] = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (merge_eff[k]) begin
        active[2*k+1] = 1'b0;
      end
    end
    if (fo_mode) begin
      active[2] = 1'b0;
      if (merge_eff[0]) begin
        active[1] = 1'b0;
        active[3] = 1'b0;
      end
    end
  end

  // port pin gating, registered so negated ports never glitch
  logic [7:0] port_out_r;
  logic [7:0] port_in_r;
  logic [7:0] active_r;
  logic [3:0] x8_r;
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      port_out_r <= 8'h00;
      port_in_r <= 8'h00;
      active_r <= 8'h00;
      x8_r <= 4'h0;
    end else begin
      port_out_r <= PORT_OUT_REQ & active;
      port_in_r <= PORT_IN & active;
      active_r <= active;
      x8_r <= merge_eff;
    end
  end

  // config and SMBus target checks, one cycle answer
  logic cfg_done_r;
  logic cfg_ur_r;
  logic smb_done_r;
  logic smb_ok_r;
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      cfg_done_r <= 1'b0;
      cfg_ur_r <= 1'b0;
      smb_done_r <= 1'b0;
      smb_ok_r <= 1'b0;
    end else begin
      cfg_done_r <= CFG_VALID;
      cfg_ur_r <= CFG_VALID & ~active[CFG_DEV];
      smb_done_r <= SMB_VALID;
      smb_ok_r <= SMB_VALID & active[SMB_PORT];
    end
  end

  // axi write and read channels
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic wr_fire;
  assign wr_fire = ~awready_r & ~wready_r & ~bvalid_r;

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (AWVALID && awready_r) begin
        awready_r <= 1'b0;
        awaddr_r <= AWADDR;
      end
      if (WVALID && wready_r) begin
        wready_r <= 1'b0;
        wdata_r <= WDATA;
        wstrb_r <= WSTRB;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && BREADY) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // control registers; switch control clears on hot reset, failover state does not
  logic [2:0] fo_ctrl_r;
  logic no_ld_hrst_r;
  logic [WDOG_W-1:0] wdog_r;
  logic sw_req_r;
  logic cur_up_r;
  logic wr_ctrl;
  logic [31:0] ctrl_new;
  assign wr_ctrl = wr_fire && awaddr_r == OFS_FO_CTRL;
  assign ctrl_new = strb_merge({29'h0, fo_ctrl_r}, wdata_r, wstrb_r);
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      fo_ctrl_r <= 3'h0;
      sw_req_r <= 1'b0;
    end else begin
      sw_req_r <= 1'b0;
      if (wr_ctrl) begin
        fo_ctrl_r <= ctrl_new[2:0];
        sw_req_r <= ctrl_new[CT_SEL] != cur_up_r; // a select differing from the current upstream starts a failover
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN || !HOT_RSTN) begin
      no_ld_hrst_r <= 1'b0;
    end else if (wr_fire && awaddr_r == OFS_SW_CTRL && wstrb_r[0]) begin
      no_ld_hrst_r <= wdata_r[SC_NO_LD_HRST];
    end
  end

  // watchdog, one decrement per microsecond, keeps running across hot reset
  logic [7:0] tick_cnt_r;
  logic wdog_exp;
  logic tick;
  assign tick = tick_cnt_r == 8'(TICK_CYC - 1);
  assign wdog_exp = tick && wdog_r == WDOG_W'(1);
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      tick_cnt_r <= 8'h00;
      wdog_r <= '0;
    end else begin
      tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
      if (wr_fire && awaddr_r == OFS_WDOG) begin
        wdog_r <= WDOG_W'(strb_merge(32'(wdog_r), wdata_r, wstrb_r));
      end else if (tick && wdog_r != '0) begin
        wdog_r <= wdog_r - WDOG_W'(1);
      end
    end
  end

  // failover sequencer; software and timer triggers arriving while busy are dropped
  fo_state_t state_r;
  logic [7:0] down_cnt_r;
  logic tgt_r;
  logic lane_sel_r;
  logic link_down_r;
  logic hot_req_r;
  logic chg_r;
  logic trig;
  logic trig_tgt;
  logic chg_set;
  logic chg_clr;
  always_comb begin
    trig = 1'b0;
    trig_tgt = cur_up_r;
    if (fo_mode && state_r == FO_IDLE) begin
      if (sw_req_r) begin
        trig = 1'b1;
        trig_tgt = ~cur_up_r;
      end else if (fo_ctrl_r[CT_SIG_EN] && UPSTREAM_SEL != cur_up_r) begin
        trig = 1'b1;
        trig_tgt = UPSTREAM_SEL;
      end else if (fo_ctrl_r[CT_TIM_EN] && wdog_exp) begin
        trig = 1'b1;
        trig_tgt = ~cur_up_r;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      state_r <= FO_IDLE;
      down_cnt_r <= 8'h00;
      tgt_r <= 1'b0;
      cur_up_r <= 1'b0;
      lane_sel_r <= 1'b0;
      link_down_r <= 1'b0;
      hot_req_r <= 1'b0;
    end else begin
      hot_req_r <= 1'b0;
      if (state_r == FO_IDLE && !trig) begin
        cur_up_r <= fo_mode & (cur_up_r | (fo_init_p2 & ~chg_r & ~cur_up_r & down_cnt_r == 8'h00));
        lane_sel_r <= fo_mode & cur_up_r;
      end
      unique case (state_r)
        FO_IDLE: begin
          if (trig) begin
            state_r <= FO_DOWN;
            tgt_r <= trig_tgt;
            down_cnt_r <= 8'h01;
            link_down_r <= 1'b1;
          end
        end
        FO_DOWN: begin
          down_cnt_r <= down_cnt_r + 8'h01;
          if (down_cnt_r == 8'(DOWN_CYC)) begin
            state_r <= FO_SWAP;
          end
        end
        FO_SWAP: begin
          cur_up_r <= tgt_r;
          lane_sel_r <= tgt_r;
          link_down_r <= 1'b0;
          hot_req_r <= ~no_ld_hrst_r;
          state_r <= FO_IDLE;
        end
      endcase
    end
  end

  // sticky change bit; a set in the same cycle as a clear wins
  assign chg_set = state_r == FO_SWAP;
  assign chg_clr = wr_fire && awaddr_r == OFS_FO_STATUS && wstrb_r[0] && wdata_r[ST_CHANGED];
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      chg_r <= 1'b0;
    end else begin
      chg_r <= chg_set | (chg_r & ~chg_clr);
    end
  end

  // read path
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (ARVALID && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
      rdata_r <= 32'h0000_0000;
      unique case (ARADDR)
        OFS_FO_STATUS: begin
          rdata_r[ST_FO_EN] <= fo_mode;
          rdata_r[ST_CUR_UP] <= cur_up_r;
          rdata_r[ST_CHANGED] <= chg_r;
          rdata_r[ST_ACTIVE_LSB +: 8] <= active_r;
          rdata_r[ST_X8_LSB +: 4] <= x8_r;
        end
        OFS_FO_CTRL: rdata_r[2:0] <= fo_ctrl_r;
        OFS_SW_CTRL: rdata_r[SC_NO_LD_HRST] <= no_ld_hrst_r;
        OFS_WDOG: rdata_r <= 32'(wdog_r);
        OFS_LINK_CAP: begin
          for (int k = 0; k < 4; k++) begin
            rdata_r[8*k +: 6] <= merge_eff[k] ? WIDTH_X8 : WIDTH_X4;
          end
        end
        default: rdata_r <= 32'h0000_0000;
      endcase
    end else if (rvalid_r && RREADY) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // outputs straight from flops
  assign PORT_OUT = port_out_r;
  assign PORT_IN_OK = port_in_r;
  assign PORT_ACTIVE = active_r;
  assign PORT_X8 = x8_r;
  assign LANE_SEL = lane_sel_r;
  assign LINK_DOWN = link_down_r;
  assign HOT_RST_REQ = hot_req_r;
  assign CFG_DONE = cfg_done_r;
  assign CFG_UR = cfg_ur_r;
  assign SMB_DONE = smb_done_r;
  assign SMB_OK = smb_ok_r;
  assign AWREADY = awready_r;
  assign WREADY = wready_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID = rvalid_r;
  assign RRESP = rresp_r;
  assign RDATA = rdata_r;

  // checks
  a_odd_merged_gate: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    merge_eff[3] |=> PORT_OUT[7] == 1'b0 && PORT_IN_OK[7] == 1'b0)
    else $error("merged odd port not negated");
  a_disabled_gate: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    dis_r[7] |-> merge_eff[3] == 1'b0 ##1 PORT_OUT[7] == 1'b0)
    else $error("disabled port leaks or merges");
  a_cfg_unsup: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    CFG_VALID |=> CFG_DONE && CFG_UR == ~$past(active[CFG_DEV]))
    else $error("config answer wrong");
  a_smb_block: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    SMB_VALID |=> SMB_DONE && SMB_OK == $past(active[SMB_PORT]))
    else $error("smbus reach wrong");
  a_fo_port2_off: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    fo_mode ##1 fo_mode |-> !PORT_ACTIVE[2] && (!PORT_X8[0] || PORT_ACTIVE[3:1] == 3'b000))
    else $error("failover port mask wrong");
  a_fo_x4_keep: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    fo_mode && !merge_eff[0] && !merge_eff[1] && !dis_r[1] && !dis_r[3]
    |=> PORT_ACTIVE[1] && PORT_ACTIVE[3])
    else $error("x4 failover dropped port 1 or 3");
  a_lane_normal: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    !fo_mode ##1 !fo_mode |-> !LANE_SEL)
    else $error("lane mux moved outside failover");
  a_down_hold: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    $rose(LINK_DOWN) |-> LINK_DOWN [*8] ##1 LINK_DOWN [*8] ##1 LINK_DOWN ##1 !LINK_DOWN)
    else $error("link down hold length wrong");
  a_hotrst_gate: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    state_r == FO_SWAP |=> HOT_RST_REQ == ~$past(no_ld_hrst_r))
    else $error("hot reset gating wrong");
  a_chg_sticky: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    chg_r && !chg_clr |=> chg_r)
    else $error("change bit lost");
  a_wdog_target: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    state_r == FO_IDLE && trig && !sw_req_r && !(fo_ctrl_r[CT_SIG_EN] && UPSTREAM_SEL != cur_up_r)
    |=> tgt_r != $past(cur_up_r))
    else $error("watchdog target not the other port");
  c_failover: cover property (@(posedge CORE_CLK) disable iff (!RSTN) state_r == FO_SWAP);
  c_merged_ur: cover property (@(posedge CORE_CLK) disable iff (!RSTN) CFG_UR && merge_eff != 4'h0);
  c_wdog_fire: cover property (@(posedge CORE_CLK) disable iff (!RSTN) wdog_exp && fo_mode);
  c_chg_race: cover property (@(posedge CORE_CLK) disable iff (!RSTN) chg_set && chg_clr);
endmodule
`default_nettype wire

// ==== root_cplx_model.sv ====
// Purpose: root complex stand-in that sweeps config requests over all eight devices
// Assumes: answers return in request order, one per request
// Notes: the device field is scrambled between sweeps, never left at its last value
`timescale 1ns/1ns
`default_nettype none
module root_cplx_model (
  input wire logic clk, // core clock
  input wire logic start, // restart a sweep
  output logic cfg_valid, // config request
  output logic [2:0] cfg_dev, // target device
  input wire logic cfg_done, // answer strobe
  input wire logic cfg_ur, // unsupported flag
  output logic [7:0] ur_map, // one bit per device
  output logic sweep_done // all answers in
);
  logic [3:0] sent_r;
  logic [3:0] got_r;
  initial begin
    sent_r = 4'h8;
    got_r = 4'h8;
    cfg_valid = 1'b0;
    cfg_dev = 3'h0;
    ur_map = 8'h00;
    sweep_done = 1'b0;
  end
  // back to back requests, one per cycle, to stress the answer path
  always @(posedge clk) begin
    cfg_valid <= !start && sent_r != 4'h8;
    cfg_dev <= (!start && sent_r != 4'h8) ? sent_r[2:0] : cfg_dev + 3'h3;
    sent_r <= start ? 4'h0 : (sent_r != 4'h8 ? sent_r + 4'h1 : sent_r);
  end
  // collect answers in order; an extra answer is ignored
  always @(posedge clk) begin
    if (start) begin
      got_r <= 4'h0;
      sweep_done <= 1'b0;
    end else if (cfg_done && got_r != 4'h8) begin
      ur_map[got_r[2:0]] <= cfg_ur;
      got_r <= got_r + 4'h1;
      sweep_done <= got_r == 4'h7;
    end
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Purpose: self-checking bench for port merge, disable and upstream failover
// Assumes: one-cycle config and SMBus answers, registered AXI4-Lite slave
// Notes: straps change only while fundamental reset is held
`timescale 1ns/1ns
`default_nettype none
module tb;
  import port_cfg_pkg::*;
  localparam int LIMIT = 20000; // whole run needs under a thousand cycles
  logic clk, rstn, hot_rstn, up_sel, cfg_valid, cfg_done, cfg_ur, smb_valid, smb_done, smb_ok;
  logic lane_sel, link_down, hot_req, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, start, sweep_done;
  logic [3:0] merge, mode, x8, wstrb;
  logic [7:0] dis, out_req, port_out, port_in, in_ok, active, awaddr, araddr, ur_map;
  logic [2:0] cfg_dev, smb_port;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int fail_count, total_checks, cycles, run, fo_len, fo_count;
  logic fo_lane, fo_hot;

  port_cfg_top port_cfg_top_i (.CORE_CLK(clk), .RSTN(rstn), .HOT_RSTN(hot_rstn),
    .MERGE_STRAP(merge), .SWITCH_MODE_STRAPS(mode), .PORT_DIS_STRAP(dis),
    .PORT_OUT_REQ(out_req), .PORT_OUT(port_out), .PORT_IN(port_in), .PORT_IN_OK(in_ok),
    .PORT_ACTIVE(active), .PORT_X8(x8), .LANE_SEL(lane_sel), .LINK_DOWN(link_down),
    .HOT_RST_REQ(hot_req), .UPSTREAM_SEL(up_sel), .CFG_VALID(cfg_valid), .CFG_DEV(cfg_dev),
    .CFG_DONE(cfg_done), .CFG_UR(cfg_ur), .SMB_VALID(smb_valid), .SMB_PORT(smb_port),
    .SMB_DONE(smb_done), .SMB_OK(smb_ok), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
  root_cplx_model root_cplx_model_i (.clk(clk), .start(start), .cfg_valid(cfg_valid),
    .cfg_dev(cfg_dev), .cfg_done(cfg_done), .cfg_ur(cfg_ur), .ur_map(ur_map),
    .sweep_done(sweep_done));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // note length and end state of every upstream retrain
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      test_done();
    end
    if (link_down) begin
      run <= run + 1;
    end else if (run != 0) begin
      fo_len <= run;
      fo_lane <= lane_sel;
      fo_hot <= hot_req;
      fo_count <= fo_count + 1;
      run <= 0;
    end
  end

  task automatic test_done();
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic do_reset(input logic [3:0] m, input logic [3:0] sw, input logic [7:0] d);
    @(posedge clk);
    rstn <= 1'b0;
    merge <= m;
    mode <= sw;
    dis <= d;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_fo(input int lead, input logic lane, input logic hot);
    int base;
    int n;
    base = fo_count;
    n = 0;
    while (fo_count == base && n < lead) begin
      @(posedge clk);
      n++;
    end
    chk("retrains", base + 1, fo_count);
    chk("down cycles", DOWN_CYC + 1, fo_len);
    chk("lane after retrain", lane, fo_lane);
    chk("hot reset pulse", hot, fo_hot);
  endtask
  task automatic sweep(input logic [7:0] exp);
    int n;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    // let the model drop the previous sweep's done flag first
    @(posedge clk);
    n = 0;
    while (!sweep_done && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("unsupported map", exp, ur_map);
  endtask
  task automatic smb_chk(input logic [2:0] p, input logic exp);
    @(posedge clk);
    smb_valid <= 1'b1;
    smb_port <= p;
    @(posedge clk);
    smb_valid <= 1'b0;
    @(posedge clk);
    chk("smbus done", 1, smb_done);
    chk("smbus reach", exp, smb_ok);
  endtask

  // every switch mode code, failover ones and an unlisted one
  task automatic modes_scn();
    logic [3:0] codes [7];
    logic fo;
    logic cur;
    logic [31:0] d;
    logic [1:0] r;
    codes = '{SWM_NORMAL, SWM_EEPROM, SWM_FO_P0, SWM_FO_P2, SWM_EE_FO_P0, SWM_EE_FO_P2, 4'h5};
    for (int i = 0; i < 7; i++) begin
      fo = i >= 2 && i <= 5;
      cur = i == 3 || i == 5;
      do_reset(4'h0, codes[i], 8'h00);
      axi_rd(OFS_FO_STATUS, d, r);
      chk("fo enabled", fo, d[ST_FO_EN]);
      chk("current up", cur, d[ST_CUR_UP]);
      chk("lane select", cur, lane_sel);
      chk("active", fo ? 8'hFB : 8'hFF, active);
      chk("active field", fo ? 8'hFB : 8'hFF, d[15:8]);
    end
  endtask
  // pairs 0/1 and 6/7 strapped, port 7 disabled, normal mode
  task automatic merge_scn();
    logic [31:0] d;
    logic [1:0] r;
    int base;
    do_reset(4'b1001, SWM_NORMAL, 8'h80);
    chk("active", 8'h7D, active);
    chk("x8 pairs", 4'h1, x8);
    axi_rd(OFS_LINK_CAP, d, r);
    chk("width port0", {2'h0, WIDTH_X8}, d[7:0]);
    chk("width port6", {2'h0, WIDTH_X4}, d[31:24]);
    @(posedge clk);
    out_req <= 8'hFF;
    port_in <= 8'hFF;
    repeat (2) @(posedge clk);
    chk("port out", 8'h7D, port_out);
    chk("port in", 8'h7D, in_ok);
    out_req <= 8'h00;
    port_in <= 8'h00;
    sweep(8'h82);
    smb_chk(3'h1, 1'b0);
    smb_chk(3'h7, 1'b0);
    smb_chk(3'h2, 1'b1);
    base = fo_count;
    up_sel <= 1'b1;
    axi_wr(OFS_FO_CTRL, 32'h7, r);
    axi_wr(OFS_WDOG, 32'h1, r);
    repeat (300) @(posedge clk);
    chk("inert retrains", base, fo_count);
    chk("inert lane", 0, lane_sel);
    up_sel <= 1'b0;
    axi_rd(8'h40, d, r);
    chk("unmapped rresp", RESP_SLVERR, r);
    chk("unmapped rdata", 0, d);
    axi_wr(8'h44, 32'h1, r);
    chk("unmapped bresp", RESP_SLVERR, r);
  endtask
  // x8 upstream failover: pair 2/3 strapped alike as the straps must be, pair 6/7 merged too
  task automatic x8_fo_scn();
    do_reset(4'b1011, SWM_FO_P0, 8'h00);
    chk("active", 8'h71, active);
    chk("x8 upstream", 1, x8[0]);
    chk("x8 pairs", 4'hB, x8);
    sweep(8'h8E);
  endtask
  // software, signal and watchdog failovers with a hot reset between
  task automatic fo_scn();
    logic [31:0] d;
    logic [1:0] r;
    do_reset(4'h0, SWM_FO_P0, 8'h00);
    axi_wr(OFS_FO_CTRL, 32'h1, r);
    wait_fo(60, 1'b1, 1'b1);
    chk("active", 8'hFB, active);
    @(posedge clk);
    hot_rstn <= 1'b0;
    repeat (2) @(posedge clk);
    hot_rstn <= 1'b1;
    axi_rd(OFS_FO_STATUS, d, r);
    chk("cur after hot", 1, d[ST_CUR_UP]);
    chk("change after hot", 1, d[ST_CHANGED]);
    axi_wr(OFS_SW_CTRL, 32'h1, r);
    axi_wr(OFS_FO_CTRL, 32'h3, r);
    wait_fo(60, 1'b0, 1'b0);
    axi_wr(OFS_FO_STATUS, 32'h1 << ST_CHANGED, r);
    axi_rd(OFS_FO_STATUS, d, r);
    chk("change cleared", 0, d[ST_CHANGED]);
    chk("cur back", 0, d[ST_CUR_UP]);
    // select kept at the current port so only the timer can start this one
    axi_wr(OFS_FO_CTRL, 32'h4, r);
    axi_wr(OFS_WDOG, 32'h2, r);
    wait_fo(400, 1'b1, 1'b0);
    axi_rd(OFS_FO_STATUS, d, r);
    chk("change by timer", 1, d[ST_CHANGED]);
    chk("cur by timer", 1, d[ST_CUR_UP]);
  endtask

  initial begin
    {rstn, up_sel, smb_valid, awvalid, wvalid, bready, arvalid, rready, start} = '0;
    {merge, mode, dis, out_req, port_in, smb_port, awaddr, araddr, wdata} = '0;
    {fail_count, total_checks, cycles, run, fo_len, fo_count} = '0;
    hot_rstn = 1'b1;
    wstrb = 4'hF;
    do_reset(4'h0, SWM_NORMAL, 8'h00);
    modes_scn();
    merge_scn();
    x8_fo_scn();
    fo_scn();
    test_done();
  end
endmodule
`default_nettype wire
